// file: pkg/ptq_pkg.sv
/*
  Shared constants for the pulse trigger qualifier: register map, control
  field layout, class and polarity codes, state encodings.
  Assumes a 32-bit AXI4-Lite register port with 6-bit byte addresses.
*/
package ptq_pkg;
  localparam int NUM_CH = 4;
  localparam int SRC_W = 2;
  localparam int ADDR_W = 6;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;

  // Byte offsets of the registers.
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_LVL_CMD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_THR_HIGH = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_THR_LOW = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_GLITCH_W = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_RUNT_W = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_RANGE_LO = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_RANGE_HI = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_HOLDOFF = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h28;

  // Control register fields.
  localparam int CTRL_W = 11;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_CLASS_LSB = 2;
  localparam int CTRL_POL_LSB = 4;
  localparam int CTRL_GLITCH_REJECT = 6;
  localparam int CTRL_RUNT_MIN = 7;
  localparam int CTRL_RANGE_OUT = 8;
  localparam int CTRL_ENABLE = 9;
  localparam int CTRL_SINGLE = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  // Level command bits and status fields.
  localparam int CMD_PRESET_A = 0;
  localparam int CMD_PRESET_B = 1;
  localparam int CMD_MIDPOINT = 2;
  localparam int STAT_BUSY = 16;

  localparam logic [1:0] CLASS_GLITCH = 2'h0;
  localparam logic [1:0] CLASS_RUNT = 2'h1;
  localparam logic [1:0] CLASS_WIDTH = 2'h2;
  localparam logic [1:0] POL_POS = 2'h0;
  localparam logic [1:0] POL_NEG = 2'h1;
  localparam logic [1:0] POL_EITHER = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RUNT_IDLE = 3'h1,
    RUNT_POS = 3'h2,
    RUNT_NEG = 3'h4
  } ptq_runt_e;

  typedef enum logic [1:0] {
    PEAK_IDLE = 2'h1,
    PEAK_RUN = 2'h2
  } ptq_peak_e;
endpackage : ptq_pkg

// file: design/ptq_top.sv
/*
  Pulse trigger qualifier: glitch, runt and width classes on one selected
  channel, with trigger level, thresholds, holdoff and an AXI4-Lite slave.
  Assumes comparator results arrive asynchronously on pins and samples
  arrive synchronous to aclk.
*/
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
// Notes on behaviour
// - One of four channels is the source for every pulse class.
// - Glitch polarity is positive, negative or either.
// - Glitch accept triggers on pulses narrower than the glitch width.
// - Glitch reject triggers on pulses wider than the glitch width.
// - Trigger level is written by software or loaded from a logic preset.
// - Midpoint request sets level halfway between source peaks.
// - Runt crosses a threshold and recrosses it without reaching the other.
// - Positive runt uses low threshold rising then falling; negative mirrors it.
// - Either polarity accepts both runt directions.
// - Runt trigger point is the recrossing of the first threshold.
// - Occurrence mode triggers on every runt.
// - Minimum-duration mode triggers only on runts longer than the width.
// - High and low thresholds are separately programmable.
// - Width class uses positive or negative polarity only.
// - Inside mode triggers when width lies between the limits.
// - Outside mode triggers when width lies outside the limits.
// - Upper limit is maximum valid width, lower limit the minimum.
// - Lower limit is forced never to exceed the upper limit.
// - Enable, single mode and holdoff apply to all classes alike.
`timescale 1ns/1ps
module ptq_top #(
  parameter int LEVEL_W = 8,
  parameter int CNT_W = 16,
  parameter int PRESET_A = 64,
  parameter int PRESET_B = 96,
  parameter int PEAK_WIN = 1024
) (
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write channels.
  input logic [ptq_pkg::ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [ptq_pkg::STRB_W-1:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // AXI4-Lite read channels.
  input logic [ptq_pkg::ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  // Comparator results per channel, asynchronous.
  input logic [ptq_pkg::NUM_CH-1:0] lvl_above,
  input logic [ptq_pkg::NUM_CH-1:0] hi_above,
  input logic [ptq_pkg::NUM_CH-1:0] lo_above,
  // Digitised samples per channel, on aclk.
  input logic [ptq_pkg::NUM_CH-1:0][LEVEL_W-1:0] sample_data,
  // Comparator references and trigger.
  output logic [LEVEL_W-1:0] trig_level,
  output logic [LEVEL_W-1:0] thr_high,
  output logic [LEVEL_W-1:0] thr_low,
  output logic trig_pulse
);
  import ptq_pkg::*;

  localparam int IDX_W = ADDR_W - 2;
  localparam int PW = $clog2(PEAK_WIN + 1);
  localparam logic [IDX_W-1:0] LAST_IDX = OFF_STATUS[ADDR_W-1:2];
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0] glitch_w, runt_w, range_lo, range_hi, holdoff_w, trig_count;
  logic aw_full, w_full, do_write;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, wr_word;
  logic [STRB_W-1:0] w_strb_q;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [31:0] reg_view [2**IDX_W];

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [STRB_W-1:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction : wmerge

  // Address and data are held separately so the master may offer them in any order.
  assign do_write = aw_full && w_full && !bvalid;
  assign wr_idx = aw_addr_q[ADDR_W-1:2];
  assign rd_idx = araddr[ADDR_W-1:2];
  assign wr_word = wmerge(reg_view[wr_idx], w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      awready <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      awready <= !((awvalid && awready) || (aw_full && !do_write));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      wready <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (wvalid && wready) begin
        w_full <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
      wready <= !((wvalid && wready) || (w_full && !do_write));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (wr_idx <= LAST_IDX) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= reg_view[rd_idx];
        rresp <= (rd_idx <= LAST_IDX) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
      arready <= !((arvalid && arready) || (rvalid && !rready));
    end
  end

  // Midpoint search state, declared here because the register view reads it.
  ptq_peak_e peak_state;
  logic [PW-1:0] peak_cnt;
  logic [LEVEL_W-1:0] peak_max, peak_min, src_sample, mid_val;
  logic [LEVEL_W:0] peak_sum;
  logic peak_done, cmd_write;

  always_comb begin
    for (int i = 0; i < 2**IDX_W; i++) begin
      reg_view[i] = '0;
    end
    reg_view[OFF_CTRL[ADDR_W-1:2]] = 32'(ctrl);
    reg_view[OFF_LEVEL[ADDR_W-1:2]] = 32'(trig_level);
    reg_view[OFF_THR_HIGH[ADDR_W-1:2]] = 32'(thr_high);
    reg_view[OFF_THR_LOW[ADDR_W-1:2]] = 32'(thr_low);
    reg_view[OFF_GLITCH_W[ADDR_W-1:2]] = 32'(glitch_w);
    reg_view[OFF_RUNT_W[ADDR_W-1:2]] = 32'(runt_w);
    reg_view[OFF_RANGE_LO[ADDR_W-1:2]] = 32'(range_lo);
    reg_view[OFF_RANGE_HI[ADDR_W-1:2]] = 32'(range_hi);
    reg_view[OFF_HOLDOFF[ADDR_W-1:2]] = 32'(holdoff_w);
    reg_view[OFF_STATUS[ADDR_W-1:2]] = 32'(trig_count);
    reg_view[OFF_STATUS[ADDR_W-1:2]][STAT_BUSY] = (peak_state == PEAK_RUN);
  end

  logic fire;
  logic [SRC_W-1:0] src;
  logic [1:0] pclass, pol;
  assign src = ctrl[CTRL_SRC_LSB +: SRC_W];
  assign pclass = ctrl[CTRL_CLASS_LSB +: 2];
  assign pol = ctrl[CTRL_POL_LSB +: 2];

  // Software writes win over the single-mode disarm in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && aw_addr_q == OFF_CTRL) begin
      ctrl <= CTRL_W'(wr_word);
    end else if (fire && ctrl[CTRL_SINGLE]) begin
      ctrl[CTRL_ENABLE] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_high <= '0;
      thr_low <= '0;
      glitch_w <= '0;
      runt_w <= '0;
      holdoff_w <= '0;
    end else if (do_write) begin
      if (aw_addr_q == OFF_THR_HIGH) begin
        thr_high <= LEVEL_W'(wr_word);
      end else if (aw_addr_q == OFF_THR_LOW) begin
        thr_low <= LEVEL_W'(wr_word);
      end else if (aw_addr_q == OFF_GLITCH_W) begin
        glitch_w <= CNT_W'(wr_word);
      end else if (aw_addr_q == OFF_RUNT_W) begin
        runt_w <= CNT_W'(wr_word);
      end else if (aw_addr_q == OFF_HOLDOFF) begin
        holdoff_w <= CNT_W'(wr_word);
      end
    end
  end

  // A lower limit above the upper one is pulled down to it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_lo <= '0;
      range_hi <= '0;
    end else if (do_write && aw_addr_q == OFF_RANGE_LO) begin
      range_lo <= (CNT_W'(wr_word) > range_hi) ? range_hi : CNT_W'(wr_word);
    end else if (do_write && aw_addr_q == OFF_RANGE_HI) begin
      range_hi <= CNT_W'(wr_word);
      if (range_lo > CNT_W'(wr_word)) begin
        range_lo <= CNT_W'(wr_word);
      end
    end
  end

  assign cmd_write = do_write && aw_addr_q == OFF_LVL_CMD;
  assign src_sample = sample_data[src];
  assign peak_done = (peak_state == PEAK_RUN) && (peak_cnt == PW'(PEAK_WIN - 1));
  assign peak_sum = {1'b0, peak_max} + {1'b0, peak_min};
  assign mid_val = peak_sum[LEVEL_W:1];

  // Peaks are tracked over a fixed window of samples, then halved.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_state <= PEAK_IDLE;
      peak_cnt <= '0;
      peak_max <= '0;
      peak_min <= '0;
    end else begin
      case (peak_state)
        PEAK_IDLE: begin
          if (cmd_write && wr_word[CMD_MIDPOINT]) begin
            peak_state <= PEAK_RUN;
            peak_cnt <= '0;
            peak_max <= src_sample;
            peak_min <= src_sample;
          end
        end
        PEAK_RUN: begin
          peak_cnt <= peak_cnt + PW'(1);
          if (src_sample > peak_max) begin
            peak_max <= src_sample;
          end
          if (src_sample < peak_min) begin
            peak_min <= src_sample;
          end
          if (peak_done) begin
            peak_state <= PEAK_IDLE;
          end
        end
        default: peak_state <= PEAK_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_level <= '0;
    end else if (peak_done) begin
      trig_level <= mid_val;
    end else if (do_write && aw_addr_q == OFF_LEVEL) begin
      trig_level <= LEVEL_W'(wr_word);
    end else if (cmd_write && wr_word[CMD_PRESET_A]) begin
      trig_level <= LEVEL_W'(PRESET_A);
    end else if (cmd_write && wr_word[CMD_PRESET_B]) begin
      trig_level <= LEVEL_W'(PRESET_B);
    end
  end

  // Two-flop synchronisers; only the second stage feeds any logic.
  logic [NUM_CH-1:0] lvl_s1, lvl_s2, hi_s1, hi_s2, lo_s1, lo_s2;
  always_ff @(posedge aclk) begin
    lvl_s1 <= lvl_above;
    lvl_s2 <= lvl_s1;
    hi_s1 <= hi_above;
    hi_s2 <= hi_s1;
    lo_s1 <= lo_above;
    lo_s2 <= lo_s1;
  end

  logic lvl_prev, hi_prev, lo_prev, seen_edge;
  logic lvl_rise, lvl_fall, hi_rise, hi_fall, lo_rise, lo_fall;
  logic [CNT_W-1:0] pulse_cnt, runt_cnt;
  assign lvl_rise = lvl_s2[src] && !lvl_prev;
  assign lvl_fall = !lvl_s2[src] && lvl_prev;
  assign hi_rise = hi_s2[src] && !hi_prev;
  assign hi_fall = !hi_s2[src] && hi_prev;
  assign lo_rise = lo_s2[src] && !lo_prev;
  assign lo_fall = !lo_s2[src] && lo_prev;

  // Cycles the level has held since its last edge, saturating.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_prev <= 1'b0;
      hi_prev <= 1'b0;
      lo_prev <= 1'b0;
      seen_edge <= 1'b0;
      pulse_cnt <= '0;
    end else begin
      lvl_prev <= lvl_s2[src];
      hi_prev <= hi_s2[src];
      lo_prev <= lo_s2[src];
      if (lvl_rise || lvl_fall) begin
        seen_edge <= 1'b1;
        pulse_cnt <= CNT_W'(1);
      end else if (pulse_cnt != CNT_MAX) begin
        pulse_cnt <= pulse_cnt + CNT_W'(1);
      end
    end
  end

  logic glitch_end, glitch_hit, width_end, width_in, width_hit;
  assign glitch_end = seen_edge && (((pol == POL_POS) && lvl_fall) ||
                      ((pol == POL_NEG) && lvl_rise) ||
                      ((pol == POL_EITHER) && (lvl_rise || lvl_fall)));
  assign glitch_hit = glitch_end && (ctrl[CTRL_GLITCH_REJECT] ?
                      (pulse_cnt > glitch_w) : (pulse_cnt < glitch_w));
  // Either polarity is not offered here and behaves as positive.
  assign width_end = seen_edge && ((pol == POL_NEG) ? lvl_rise : lvl_fall);
  assign width_in = (pulse_cnt >= range_lo) && (pulse_cnt <= range_hi);
  assign width_hit = width_end && (ctrl[CTRL_RANGE_OUT] ? !width_in : width_in);

  ptq_runt_e runt_state;
  logic runt_pos_end, runt_neg_end, runt_hit;
  assign runt_pos_end = (runt_state == RUNT_POS) && lo_fall && !hi_rise;
  assign runt_neg_end = (runt_state == RUNT_NEG) && hi_rise && !lo_fall;
  assign runt_hit = ((runt_pos_end && pol != POL_NEG) || (runt_neg_end && pol != POL_POS)) &&
                    (!ctrl[CTRL_RUNT_MIN] || runt_cnt > runt_w);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      runt_state <= RUNT_IDLE;
      runt_cnt <= '0;
    end else begin
      if (runt_cnt != CNT_MAX) begin
        runt_cnt <= runt_cnt + CNT_W'(1);
      end
      case (runt_state)
        RUNT_IDLE: begin
          if (lo_rise && !hi_s2[src]) begin
            runt_state <= RUNT_POS;
            runt_cnt <= CNT_W'(1);
          end else if (hi_fall && lo_s2[src]) begin
            runt_state <= RUNT_NEG;
            runt_cnt <= CNT_W'(1);
          end
        end
        RUNT_POS: begin
          if (hi_rise || lo_fall) begin
            runt_state <= RUNT_IDLE;
          end
        end
        RUNT_NEG: begin
          if (lo_fall || hi_rise) begin
            runt_state <= RUNT_IDLE;
          end
        end
        default: runt_state <= RUNT_IDLE;
      endcase
    end
  end

  logic qualified;
  logic [CNT_W-1:0] holdoff_cnt;
  always_comb begin
    qualified = 1'b0;
    case (pclass)
      CLASS_GLITCH: qualified = glitch_hit;
      CLASS_RUNT: qualified = runt_hit;
      CLASS_WIDTH: qualified = width_hit;
      default: qualified = 1'b0;
    endcase
  end
  assign fire = qualified && ctrl[CTRL_ENABLE] && (holdoff_cnt == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_pulse <= 1'b0;
      holdoff_cnt <= '0;
      trig_count <= '0;
    end else begin
      trig_pulse <= fire;
      if (fire) begin
        holdoff_cnt <= holdoff_w;
        trig_count <= trig_count + CNT_W'(1);
      end else if (holdoff_cnt != '0) begin
        holdoff_cnt <= holdoff_cnt - CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_glitch_accept: assert property (trig_pulse && $past(pclass == CLASS_GLITCH) &&
    !$past(ctrl[CTRL_GLITCH_REJECT]) |-> $past(pulse_cnt) < $past(glitch_w))
    else $error("glitch accept fired on a wide pulse");
  a_glitch_reject: assert property (trig_pulse && $past(pclass == CLASS_GLITCH) &&
    $past(ctrl[CTRL_GLITCH_REJECT]) |-> $past(pulse_cnt) > $past(glitch_w))
    else $error("glitch reject fired on a narrow pulse");
  a_glitch_polarity: assert property (trig_pulse && $past(pclass == CLASS_GLITCH) &&
    $past(pol == POL_POS) |-> $past(lvl_fall))
    else $error("positive glitch fired off a falling edge");
  a_range_inside: assert property (trig_pulse && $past(pclass == CLASS_WIDTH) &&
    !$past(ctrl[CTRL_RANGE_OUT]) |-> $past(pulse_cnt) >= $past(range_lo) &&
    $past(pulse_cnt) <= $past(range_hi))
    else $error("inside width fired out of range");
  a_range_outside: assert property (trig_pulse && $past(pclass == CLASS_WIDTH) &&
    $past(ctrl[CTRL_RANGE_OUT]) |-> $past(pulse_cnt) < $past(range_lo) ||
    $past(pulse_cnt) > $past(range_hi))
    else $error("outside width fired in range");
  a_width_edge: assert property (trig_pulse && $past(pclass == CLASS_WIDTH) |->
    ($past(pol == POL_NEG) ? $past(lvl_rise) : $past(lvl_fall)))
    else $error("width trigger on wrong edge");
  a_range_order: assert property (range_lo <= range_hi)
    else $error("lower limit above upper limit");
  a_runt_point: assert property (trig_pulse && $past(pclass == CLASS_RUNT) |->
    $past(runt_state) == RUNT_POS && $past(lo_fall) ||
    $past(runt_state) == RUNT_NEG && $past(hi_rise))
    else $error("runt trigger not at recrossing");
  a_runt_width: assert property (trig_pulse && $past(pclass == CLASS_RUNT) &&
    $past(ctrl[CTRL_RUNT_MIN]) |-> $past(runt_cnt) > $past(runt_w))
    else $error("short runt passed minimum duration");
  a_holdoff_quiet: assert property (trig_pulse && holdoff_w != '0 |=>
    !trig_pulse [*1] ##0 holdoff_cnt == $past(holdoff_w) - CNT_W'(1))
    else $error("holdoff not honoured");
  a_midpoint_load: assert property (peak_done |=> trig_level == $past(mid_val) &&
    peak_state == PEAK_IDLE)
    else $error("midpoint level not loaded");
  a_preset_load: assert property (cmd_write && wr_word[CMD_PRESET_A] && !peak_done |=>
    trig_level == LEVEL_W'(PRESET_A))
    else $error("preset level not loaded");

  c_glitch: cover property (trig_pulse && $past(pclass == CLASS_GLITCH));
  c_runt_neg: cover property ($past(runt_neg_end) && trig_pulse);
  c_width_out: cover property (trig_pulse && $past(ctrl[CTRL_RANGE_OUT]));
  c_midpoint: cover property (peak_done);
endmodule : ptq_top

// file: tb/ptq_comp_model.sv
/*
  Comparator model of the four input channels: each channel's level code is
  compared with the block's references and handed back as its sample.
  Assumes the bench changes level codes just after a rising clock edge.
*/
`timescale 1ns/1ps
module ptq_comp_model (
  // Channel levels from the bench, references from the block.
  input logic [3:0][7:0] level,
  input logic [7:0] trig_level,
  input logic [7:0] thr_high,
  input logic [7:0] thr_low,
  // Comparator results and samples.
  output logic [3:0] lvl_above,
  output logic [3:0] hi_above,
  output logic [3:0] lo_above,
  output logic [3:0][7:0] sample_data
);
  // Equal counts as below, so a level parked on a reference never chatters.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      lvl_above[c] = level[c] > trig_level;
      hi_above[c] = level[c] > thr_high;
      lo_above[c] = level[c] > thr_low;
    end
  end
  assign sample_data = level;
endmodule : ptq_comp_model

// file: tb/test_pulse_trigger_qualifier.sv
/*
  Self-checking bench for the pulse trigger qualifier: registers, level
  presets and midpoint, glitch, runt and width classes, source, holdoff.
  Assumes ptq_comp_model turns channel level codes into comparator results.
*/
`timescale 1ns/1ps
module test_pulse_trigger_qualifier;
  import ptq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF, lvl_above, hi_above, lo_above;
  logic awready, wready, bvalid, arready, rvalid, trig_pulse;
  logic [1:0] bresp, rresp, br, rr;
  logic [3:0][7:0] sample_data, level = {4{8'h00}};
  logic [7:0] trig_level, thr_high, thr_low;
  int fail_count = 0, checks = 0, seen = 0, mark = 0, want = 0;
  ptq_top #(.PRESET_A(32'h0000_0040), .PRESET_B(32'h0000_0060), .PEAK_WIN(32'h0000_0010))
    ptq_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .lvl_above, .hi_above, .lo_above, .sample_data, .trig_level,
    .thr_high, .thr_low, .trig_pulse);
  ptq_comp_model ptq_comp_model_i (.level, .trig_level, .thr_high, .thr_low, .lvl_above,
    .hi_above, .lo_above, .sample_data);
  initial forever #20 aclk = ~aclk;
  // Every cycle that is not low is counted, so a long or unknown trigger is caught.
  always @(posedge aclk) seen += int'(trig_pulse !== 1'b0);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge aclk);
    while (bvalid !== 1'b1) begin
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      @(posedge aclk);
    end
    br = bresp;
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (rvalid !== 1'b1) begin
      arvalid <= arvalid & ~arready;
      @(posedge aclk);
    end
    rr = rresp;
    chk(rdata, e);
  endtask : rdc
  function automatic logic [31:0] cw(input logic [1:0] s, c, p, input logic [2:0] f);
    return {22'h0, 1'b1, f, p, c, s};
  endfunction : cw
  task automatic pls(input int c, input logic [7:0] b, h, input int n);
    level[c] <= h;
    repeat (n) @(posedge aclk);
    level[c] <= b;
    repeat (14) @(posedge aclk);
  endtask : pls
  // Levels move only while disarmed, so a base change is never judged.
  task automatic arm(input logic [31:0] c, input logic [7:0] b);
    wr(OFF_CTRL, 32'h0000_0000);
    level <= {4{b}};
    repeat (8) @(posedge aclk);
    wr(OFF_CTRL, c);
  endtask : arm
  task automatic ok(input int n);
    chk(32'(seen - mark), 32'(n));
    mark = seen;
    want += n;
  endtask : ok
  // A positive pulse from a low base, then a dip from a high base.
  task automatic duo(input logic [1:0] cls, p, input logic [2:0] f,
      input logic [7:0] hp, hn, input int n, ep, en);
    arm(cw(2'h0, cls, p, f), 8'h20);
    pls(0, 8'h20, hp, n);
    ok(ep);
    arm(cw(2'h0, cls, p, f), 8'hF0);
    pls(0, 8'hF0, hn, n);
    ok(en);
  endtask : duo
  task automatic t_regs;
    rdc(OFF_CTRL, 32'h0000_0000);
    rdc(6'h2C, 32'h0000_0000);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(6'h30, 32'h0000_00FF);
    chk(32'(br), 32'(RESP_SLVERR));
    wr(OFF_LEVEL, 32'h0000_0033);
    chk(32'(trig_level), 32'h0000_0033);
    wr(OFF_LVL_CMD, 32'h0000_0001);
    rdc(OFF_LEVEL, 32'h0000_0040);
    wr(OFF_LVL_CMD, 32'h0000_0002);
    rdc(OFF_LEVEL, 32'h0000_0060);
    wr(OFF_THR_HIGH, 32'h0000_00A0);
    wr(OFF_THR_LOW, 32'h0000_0050);
    chk(32'({thr_high, thr_low}), 32'h0000_A050);
    wr(OFF_RANGE_HI, 32'h0000_0008);
    wr(OFF_RANGE_LO, 32'h0000_0014);
    rdc(OFF_RANGE_LO, 32'h0000_0008);
    wr(OFF_RANGE_LO, 32'h0000_0004);
    level[0] <= 8'h10;
    wr(OFF_LVL_CMD, 32'h0000_0004);
    level[0] <= 8'h90;
    rdc(OFF_STATUS, 32'h0001_0000);
    level[0] <= 8'h10;
    repeat (30) @(posedge aclk);
    rdc(OFF_LEVEL, 32'h0000_0050);
    wr(OFF_LEVEL, 32'h0000_0080);
    wr(OFF_GLITCH_W, 32'h0000_0005);
    wr(OFF_RUNT_W, 32'h0000_0006);
  endtask : t_regs
  task automatic t_glitch;
    for (int p = 0; p < 3; p++)
      duo(CLASS_GLITCH, 2'(p), 3'h0, 8'hF0, 8'h20, 2, int'(p != 1), int'(p != 0));
    duo(CLASS_GLITCH, POL_POS, 3'h0, 8'hF0, 8'h20, 9, 0, 0);
    duo(CLASS_GLITCH, POL_POS, 3'h1, 8'hF0, 8'h20, 9, 1, 1);
    duo(CLASS_GLITCH, POL_POS, 3'h1, 8'hF0, 8'h20, 2, 0, 1);
  endtask : t_glitch
  task automatic t_runt;
    for (int p = 0; p < 3; p++)
      duo(CLASS_RUNT, 2'(p), 3'h0, 8'h78, 8'h78, 4, int'(p != 1), int'(p != 0));
    duo(CLASS_RUNT, POL_EITHER, 3'h0, 8'hF0, 8'h20, 4, 0, 0);
    duo(CLASS_RUNT, POL_POS, 3'h2, 8'h78, 8'h78, 3, 0, 0);
    duo(CLASS_RUNT, POL_NEG, 3'h2, 8'h78, 8'h78, 10, 0, 1);
  endtask : t_runt
  task automatic t_width;
    duo(CLASS_WIDTH, POL_POS, 3'h0, 8'hF0, 8'h20, 6, 1, 0);
    duo(CLASS_WIDTH, POL_NEG, 3'h0, 8'hF0, 8'h20, 6, 0, 1);
    duo(CLASS_WIDTH, POL_POS, 3'h0, 8'hF0, 8'h20, 12, 0, 0);
    duo(CLASS_WIDTH, POL_POS, 3'h0, 8'hF0, 8'h20, 2, 0, 0);
    duo(CLASS_WIDTH, POL_POS, 3'h4, 8'hF0, 8'h20, 12, 1, 1);
    duo(CLASS_WIDTH, POL_POS, 3'h4, 8'hF0, 8'h20, 6, 0, 1);
  endtask : t_width
  task automatic t_source;
    for (int s = 0; s < 4; s++) begin
      arm(cw(2'(s), CLASS_GLITCH, POL_POS, 3'h0), 8'h20);
      pls((s + 1) % 4, 8'h20, 8'hF0, 2);
      pls(s, 8'h20, 8'hF0, 2);
      ok(1);
    end
    wr(OFF_HOLDOFF, 32'h0000_0028);
    arm(cw(2'h0, CLASS_GLITCH, POL_POS, 3'h0), 8'h20);
    pls(0, 8'h20, 8'hF0, 2);
    pls(0, 8'h20, 8'hF0, 2);
    repeat (40) @(posedge aclk);
    pls(0, 8'h20, 8'hF0, 2);
    ok(2);
    repeat (40) @(posedge aclk);
    // Single mode: the first trigger disarms, so the second pulse is ignored.
    arm(cw(2'h0, CLASS_GLITCH, POL_POS, 3'h0) | 32'h0000_0400, 8'h20);
    pls(0, 8'h20, 8'hF0, 2);
    repeat (40) @(posedge aclk);
    pls(0, 8'h20, 8'hF0, 2);
    ok(1);
    rdc(OFF_CTRL, 32'h0000_0400);
    rdc(OFF_STATUS, 32'(want));
  endtask : t_source
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_glitch;
    t_runt;
    t_width;
    t_source;
    wrap_up;
  end
  // About ten times the expected run, so only a real hang gets here.
  initial begin
    #800000;
    fail_count++;
    wrap_up;
  end
endmodule : test_pulse_trigger_qualifier
